//--- mife_framer.sv
`include "mife_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module mife_framer #(
   parameter logic [7:0] ID_APPLICATION_SPECIFIC_ELEMENT  = 8'h01, // Arbitrary element codes.
   parameter logic [7:0] ID_PROBE = 8'h02,
   parameter logic [7:0] ID_HIB   = 8'h03,
   parameter logic [7:0] ID_MASTER_KEY_IDENTIFIER  = 8'h04,
   parameter logic [7:0] ID_MAB   = 8'h05
) (
   input  wire logic                  core_clk_i,
   input  wire logic                  sys_rst_i,
   input  wire logic                  tx_start_i,
   input  wire mife_pkg::mife_tx_hdr_t tx_hdr_i,
   input  wire logic                  tx_ent_valid_i,
   input  wire logic [127:0]          tx_ent_i,
   output logic                       tx_ent_ready_o,
   output logic                       tx_valid_o,
   output logic [7:0]                 tx_byte_o,
   input  wire logic                  tx_ready_i,
   output logic                       tx_busy_o,
   output logic                       tx_err_o,
   input  wire logic                  rx_start_i,
   input  wire logic                  rx_valid_i,
   input  wire logic [7:0]            rx_byte_i,
   output logic                       rx_hdr_valid_o,
   output mife_pkg::mife_rx_hdr_t     rx_hdr_o,
   output logic                       rx_ent_valid_o,
   output logic [127:0]               rx_ent_o,
   output logic                       rx_wake_next_o,
   output logic                       rx_err_o
);

   function automatic logic [2:0] hdr_size(input mife_pkg::mife_kind_t k);
      unique case (k)
         mife_pkg::MIFE_APPLICATION_SPECIFIC_ELEMENT:  hdr_size = `MIFE_HDR_APPLICATION_SPECIFIC_ELEMENT;
         mife_pkg::MIFE_PROBE: hdr_size = `MIFE_HDR_PROBE;
         default:              hdr_size = `MIFE_HDR_NONE;
      endcase
   endfunction

   function automatic logic [4:0] ent_size(input mife_pkg::mife_kind_t k);
      unique case (k)
         mife_pkg::MIFE_HIB:  ent_size = `MIFE_ENT_HIB;
         mife_pkg::MIFE_MASTER_KEY_IDENTIFIER: ent_size = `MIFE_ENT_MASTER_KEY_IDENTIFIER;
         mife_pkg::MIFE_MAB:  ent_size = `MIFE_ENT_MAB;
         default:             ent_size = `MIFE_ENT_OPAQUE;
      endcase
   endfunction

   function automatic logic [7:0] id_of(input mife_pkg::mife_kind_t k);
      unique case (k)
         mife_pkg::MIFE_APPLICATION_SPECIFIC_ELEMENT:  id_of = ID_APPLICATION_SPECIFIC_ELEMENT;
         mife_pkg::MIFE_PROBE: id_of = ID_PROBE;
         mife_pkg::MIFE_HIB:   id_of = ID_HIB;
         mife_pkg::MIFE_MASTER_KEY_IDENTIFIER:  id_of = ID_MASTER_KEY_IDENTIFIER;
         default:              id_of = ID_MAB;
      endcase
   endfunction

   // Length must cover the fixed header and a whole number of entries.
   function automatic logic len_ok(input mife_pkg::mife_kind_t k,
                                   input logic [7:0] len);
      unique case (k)
         mife_pkg::MIFE_HIB:  len_ok = (len % 8'h03) == 8'h00;
         mife_pkg::MIFE_MASTER_KEY_IDENTIFIER: len_ok = len[3:0] == 4'h0;
         mife_pkg::MIFE_MAB:  len_ok = len[2:0] == 3'h0;
         default:             len_ok = len >= {5'h00, hdr_size(k)};
      endcase
   endfunction

   // Transmit side.
   typedef enum {E_IDLE, E_ID, E_LEN, E_HDR, E_BODY} mife_enc_st_t;

   mife_enc_st_t          enc_st;
   mife_pkg::mife_kind_t  enc_kind;
   logic [7:0]            enc_len;
   logic [7:0]            ents_left;
   logic [2:0]            hdr_left;
   logic [4:0]            byte_left;
   logic [31:0]           hdr_sh;
   logic [127:0]          ent_sh;
   logic [11:0]           next_len;
   logic                  adv;
   logic                  ent_take;

   assign next_len = {9'h000, hdr_size(tx_hdr_i.kind)} +
                     12'(tx_hdr_i.count) *
                     12'(ent_size(tx_hdr_i.kind));
   assign adv      = !tx_valid_o || tx_ready_i;
   assign ent_take = tx_ent_valid_i && tx_ent_ready_o;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         enc_st     <= E_IDLE;
         enc_kind   <= mife_pkg::MIFE_APPLICATION_SPECIFIC_ELEMENT;
         enc_len    <= 8'h00;
         ents_left  <= 8'h00;
         hdr_left   <= 3'h0;
         byte_left  <= 5'h00;
         hdr_sh     <= 32'h0000_0000;
         ent_sh     <= 128'h0;
         tx_valid_o <= 1'b0;
         tx_byte_o  <= 8'h00;
         tx_err_o   <= 1'b0;
      end else begin
         tx_err_o <= 1'b0;
         if (tx_valid_o && tx_ready_i) begin
            tx_valid_o <= 1'b0;
         end
         unique case (enc_st)
            E_IDLE: begin
               // A start is only heard once the last octet has left.
               if (tx_start_i && !tx_busy_o) begin
                  if (next_len > `MIFE_LEN_MAX) begin
                     tx_err_o <= 1'b1;
                  end else begin
                     enc_kind  <= tx_hdr_i.kind;
                     enc_len   <= next_len[7:0];
                     ents_left <= tx_hdr_i.count;
                     // Target first, then specifier, each low octet first.
                     hdr_sh <= (tx_hdr_i.kind == mife_pkg::MIFE_PROBE) ?
                               {tx_hdr_i.spec, tx_hdr_i.target} :
                               {16'h0000, tx_hdr_i.spec};
                     enc_st <= E_ID;
                  end
               end
            end
            E_ID: begin
               if (adv) begin
                  tx_byte_o  <= id_of(enc_kind);
                  tx_valid_o <= 1'b1;
                  enc_st     <= E_LEN;
               end
            end
            E_LEN: begin
               if (adv) begin
                  tx_byte_o  <= enc_len;
                  tx_valid_o <= 1'b1;
                  hdr_left   <= hdr_size(enc_kind);
                  if (hdr_size(enc_kind) != 3'h0) begin
                     enc_st <= E_HDR;
                  end else begin
                     enc_st <= (ents_left != 8'h00) ? E_BODY : E_IDLE;
                  end
               end
            end
            E_HDR: begin
               if (adv) begin
                  tx_byte_o  <= hdr_sh[7:0];
                  tx_valid_o <= 1'b1;
                  hdr_sh     <= {8'h00, hdr_sh[31:8]};
                  hdr_left   <= hdr_left - 3'h1;
                  if (hdr_left == 3'h1) begin
                     enc_st <= (ents_left != 8'h00) ? E_BODY : E_IDLE;
                  end
               end
            end
            E_BODY: begin
               if (ent_take) begin
                  // Client values go out as given.
                  ent_sh    <= tx_ent_i;
                  byte_left <= ent_size(enc_kind);
               end else if (byte_left != 5'h00 && adv) begin
                  tx_byte_o  <= ent_sh[7:0];
                  tx_valid_o <= 1'b1;
                  ent_sh     <= {8'h00, ent_sh[127:8]};
                  byte_left  <= byte_left - 5'h01;
                  if (byte_left == 5'h01) begin
                     ents_left <= ents_left - 8'h01;
                     if (ents_left == 8'h01) begin
                        enc_st <= E_IDLE;
                     end
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         tx_ent_ready_o <= 1'b0;
         tx_busy_o      <= 1'b0;
      end else begin
         tx_ent_ready_o <= enc_st == E_BODY && byte_left == 5'h00 &&
                           ents_left != 8'h00 && !ent_take;
         tx_busy_o      <= (enc_st != E_IDLE) ||
                           (tx_valid_o && !tx_ready_i) ||
                           (tx_start_i && !tx_busy_o &&
                            next_len <= `MIFE_LEN_MAX);
      end
   end

   // Receive side.
   typedef enum {P_ID, P_LEN, P_HDR, P_BODY, P_SKIP} mife_par_st_t;

   mife_par_st_t          par_st;
   mife_pkg::mife_kind_t  par_kind;
   logic                  par_known;
   logic [7:0]            par_rem;
   logic [2:0]            par_hidx;
   logic [4:0]            par_bidx;
   logic [31:0]           hdr_acc;
   logic [127:0]          ent_acc;
   logic [31:0]           next_hdr;
   logic [127:0]          next_ent;

   always_comb begin
      next_hdr = hdr_acc;
      next_ent = ent_acc;
      next_hdr[8 * par_hidx[1:0] +: 8] = rx_byte_i;
      next_ent[8 * par_bidx[3:0] +: 8] = rx_byte_i;
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         par_st         <= P_ID;
         par_kind       <= mife_pkg::MIFE_APPLICATION_SPECIFIC_ELEMENT;
         par_known      <= 1'b0;
         par_rem        <= 8'h00;
         par_hidx       <= 3'h0;
         par_bidx       <= 5'h00;
         hdr_acc        <= 32'h0000_0000;
         ent_acc        <= 128'h0;
         rx_hdr_valid_o <= 1'b0;
         rx_hdr_o       <= '0;
         rx_ent_valid_o <= 1'b0;
         rx_ent_o       <= 128'h0;
         rx_wake_next_o <= 1'b0;
         rx_err_o       <= 1'b0;
      end else begin
         rx_hdr_valid_o <= 1'b0;
         rx_ent_valid_o <= 1'b0;
         rx_wake_next_o <= 1'b0;
         rx_err_o       <= 1'b0;
         if (rx_start_i) begin
            par_st <= P_ID;
         end else if (rx_valid_i) begin
            unique case (par_st)
               P_ID: begin
                  par_known <= 1'b1;
                  par_st    <= P_LEN;
                  if (rx_byte_i == ID_APPLICATION_SPECIFIC_ELEMENT) begin
                     par_kind <= mife_pkg::MIFE_APPLICATION_SPECIFIC_ELEMENT;
                  end else if (rx_byte_i == ID_PROBE) begin
                     par_kind <= mife_pkg::MIFE_PROBE;
                  end else if (rx_byte_i == ID_HIB) begin
                     par_kind <= mife_pkg::MIFE_HIB;
                  end else if (rx_byte_i == ID_MASTER_KEY_IDENTIFIER) begin
                     par_kind <= mife_pkg::MIFE_MASTER_KEY_IDENTIFIER;
                  end else if (rx_byte_i == ID_MAB) begin
                     par_kind <= mife_pkg::MIFE_MAB;
                  end else begin
                     par_known <= 1'b0;
                  end
               end
               P_LEN: begin
                  par_rem  <= rx_byte_i;
                  par_hidx <= 3'h0;
                  par_bidx <= 5'h00;
                  hdr_acc  <= 32'h0000_0000;
                  ent_acc  <= 128'h0;
                  rx_hdr_o.kind   <= par_kind;
                  rx_hdr_o.len    <= rx_byte_i;
                  rx_hdr_o.target <= 16'h0000;
                  rx_hdr_o.spec   <= 16'h0000;
                  if (par_known && !len_ok(par_kind, rx_byte_i)) begin
                     rx_err_o <= 1'b1;
                  end
                  if (!par_known || !len_ok(par_kind, rx_byte_i)) begin
                     par_st <= (rx_byte_i == 8'h00) ? P_ID : P_SKIP;
                  end else if (hdr_size(par_kind) != 3'h0) begin
                     par_st <= P_HDR;
                  end else begin
                     rx_hdr_valid_o <= 1'b1;
                     par_st <= (rx_byte_i == 8'h00) ? P_ID : P_BODY;
                  end
               end
               P_HDR: begin
                  hdr_acc  <= next_hdr;
                  par_hidx <= par_hidx + 3'h1;
                  par_rem  <= par_rem - 8'h01;
                  if (par_hidx + 3'h1 == hdr_size(par_kind)) begin
                     rx_hdr_valid_o <= 1'b1;
                     if (par_kind == mife_pkg::MIFE_PROBE) begin
                        rx_hdr_o.target <= next_hdr[15:0];
                        rx_hdr_o.spec   <= next_hdr[31:16];
                     end else begin
                        rx_hdr_o.spec   <= next_hdr[15:0];
                     end
                     par_st <= (par_rem == 8'h01) ? P_ID : P_BODY;
                  end
               end
               P_BODY: begin
                  par_rem <= par_rem - 8'h01;
                  if (par_bidx + 5'h01 == ent_size(par_kind)) begin
                     // Opaque octets come out one per entry.
                     rx_ent_valid_o <= 1'b1;
                     rx_ent_o       <= next_ent;
                     rx_wake_next_o <= par_kind == mife_pkg::MIFE_HIB &&
                        next_ent[`MIFE_HIB_CD_LSB +: `MIFE_HIB_CD_W] ==
                        8'h00;
                     ent_acc  <= 128'h0;
                     par_bidx <= 5'h00;
                  end else begin
                     ent_acc  <= next_ent;
                     par_bidx <= par_bidx + 5'h01;
                  end
                  if (par_rem == 8'h01) begin
                     par_st <= P_ID;
                  end
               end
               P_SKIP: begin
                  par_rem <= par_rem - 8'h01;
                  if (par_rem == 8'h01) begin
                     par_st <= P_ID;
                  end
               end
            endcase
         end
      end
   end

endmodule // mife_framer

`default_nettype wire

//--- mife_defines.svh
`ifndef MIFE_DEFINES_SVH
`define MIFE_DEFINES_SVH

// Octets of fixed header that follow the length field, per element kind.
`define MIFE_HDR_APPLICATION_SPECIFIC_ELEMENT    3'h2
`define MIFE_HDR_PROBE   3'h4
`define MIFE_HDR_NONE    3'h0

// Octets in one repeated entry, per element kind.
`define MIFE_ENT_OPAQUE  5'h01
`define MIFE_ENT_HIB     5'h03
`define MIFE_ENT_MASTER_KEY_IDENTIFIER    5'h10
`define MIFE_ENT_MAB     5'h08

// Field positions inside a hibernation anchor entry.
`define MIFE_HIB_CD_LSB  16
`define MIFE_HIB_CD_W    8

// Largest value the one-octet length field can hold.
`define MIFE_LEN_MAX     12'h0FF

`endif

//--- mife_pkg.sv
package mife_pkg;

   typedef enum logic [2:0] {
      MIFE_APPLICATION_SPECIFIC_ELEMENT,
      MIFE_PROBE,
      MIFE_HIB,
      MIFE_MASTER_KEY_IDENTIFIER,
      MIFE_MAB
   } mife_kind_t;

   // Request to build one element. count is the number of entries, or
   // of opaque octets for the application-specific and probe kinds.
   typedef struct packed {
      mife_kind_t  kind;
      logic [7:0]  count;
      logic [15:0] target;
      logic [15:0] spec;
   } mife_tx_hdr_t;

   // Header of a parsed element.
   typedef struct packed {
      mife_kind_t  kind;
      logic [7:0]  len;
      logic [15:0] target;
      logic [15:0] spec;
   } mife_rx_hdr_t;

endpackage

//--- mife_framer_chk.sv
`timescale 1ns/1ps
`default_nettype none

module mife_framer_chk #(
   parameter logic [7:0] ID_HIB = 8'h03
) (
   input wire logic                   core_clk_i,
   input wire logic                   sys_rst_i,
   input wire logic                   tx_start_i,
   input wire mife_pkg::mife_tx_hdr_t tx_hdr_i,
   input wire logic                   tx_ent_valid_i,
   input wire logic                   tx_ent_ready_o,
   input wire logic                   tx_valid_o,
   input wire logic [7:0]             tx_byte_o,
   input wire logic                   tx_ready_i,
   input wire logic                   tx_busy_o,
   input wire logic                   tx_err_o,
   input wire logic                   rx_hdr_valid_o,
   input wire mife_pkg::mife_rx_hdr_t rx_hdr_o,
   input wire logic                   rx_ent_valid_o,
   input wire logic [127:0]           rx_ent_o,
   input wire logic                   rx_wake_next_o,
   input wire logic                   rx_err_o
);
   logic [11:0] len_req;
   logic        prev_acc;
   logic        start_ok;

   assign start_ok = tx_start_i && !tx_busy_o && !prev_acc;

   always_ff @(posedge core_clk_i) begin
      prev_acc <= !sys_rst_i && start_ok;
   end

   always_comb begin
      case (tx_hdr_i.kind)
         mife_pkg::MIFE_APPLICATION_SPECIFIC_ELEMENT:  len_req = 12'h002 + 12'(tx_hdr_i.count);
         mife_pkg::MIFE_PROBE: len_req = 12'h004 + 12'(tx_hdr_i.count);
         mife_pkg::MIFE_HIB:   len_req = 12'(tx_hdr_i.count) * 12'h003;
         mife_pkg::MIFE_MASTER_KEY_IDENTIFIER:  len_req = 12'(tx_hdr_i.count) * 12'h010;
         default:              len_req = 12'(tx_hdr_i.count) * 12'h008;
      endcase
   end

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_big;  start_ok && len_req > 12'h0FF;  endsequence
   sequence s_fits; start_ok && len_req <= 12'h0FF; endsequence
   sequence s_hib_go; s_fits ##0 tx_hdr_i.kind == mife_pkg::MIFE_HIB;
   endsequence

   AST_OVERSIZE: assert property (s_big |-> ##[1:2] tx_err_o)
      else $error("oversize start not refused");
   AST_REFUSE_IDLE: assert property (s_big |=> !tx_busy_o [*3])
      else $error("refused start went busy");
   AST_FITS: assert property (s_fits |=> tx_busy_o && !tx_err_o)
      else $error("legal start not taken");
   AST_FIRST_ID: assert property (s_hib_go |-> ##2 tx_byte_o == ID_HIB)
      else $error("first octet is not the identifier");
   AST_TX_HOLD: assert property (tx_valid_o && !tx_ready_i |=>
      tx_valid_o && $stable(tx_byte_o))
      else $error("octet changed while stalled");
   AST_TX_END: assert property ($fell(tx_busy_o) |-> !tx_valid_o)
      else $error("octet left after element end");
   AST_ENT_ONE: assert property (tx_ent_ready_o && tx_ent_valid_i |=>
      !tx_ent_ready_o)
      else $error("entry ready held after take");
   AST_WAKE_ZERO: assert property (rx_ent_valid_o &&
      rx_hdr_o.kind == mife_pkg::MIFE_HIB |->
      rx_wake_next_o == (rx_ent_o[23:16] == 8'h00))
      else $error("wake flag wrong");
   AST_WAKE_ONLY: assert property (rx_wake_next_o |-> rx_ent_valid_o)
      else $error("wake flag without entry");
   AST_HIB_LEN: assert property (rx_hdr_valid_o &&
      rx_hdr_o.kind == mife_pkg::MIFE_HIB |-> rx_hdr_o.len % 8'h03 == 8'h00)
      else $error("hibernation length not whole");
   AST_MASTER_KEY_IDENTIFIER_LEN: assert property (rx_hdr_valid_o &&
      rx_hdr_o.kind == mife_pkg::MIFE_MASTER_KEY_IDENTIFIER |-> rx_hdr_o.len[3:0] == 4'h0)
      else $error("key list length not whole");
   AST_RX_ERR: assert property (rx_err_o |=> !rx_err_o && !rx_hdr_valid_o)
      else $error("error pulse too long");
endmodule // mife_framer_chk

`default_nettype wire

//--- mife_sink_model.sv
`timescale 1ns/1ps
`default_nettype none

module mife_sink_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       slow_i,
   input  wire logic       valid_i,
   input  wire logic [7:0] byte_i,
   output logic            ready_o,
   output logic            echo_valid_o,
   output logic [7:0]      echo_byte_o
);
   logic [7:0] got[$];
   logic [7:0] held;
   logic [1:0] tick = 2'h0;
   logic       take;

   initial {ready_o, echo_valid_o, echo_byte_o} = 10'h000;

   // A slow sink takes one octet in four. Taken octets are echoed to the
   // parser a cycle later; an idle echo line inverts its value every cycle.
   always @(posedge clk_i) begin
      take = !rst_i && valid_i && ready_o;
      held = byte_i;
      if (take) got.push_back(held);
      #1;
      tick = tick + 2'h1;
      ready_o = !rst_i && (!slow_i || tick == 2'h3);
      echo_valid_o = take;
      echo_byte_o = take ? held : ~echo_byte_o;
   end
endmodule // mife_sink_model

`default_nettype wire

//--- mife_framer_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fail_count++; \
   $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end

module mife_framer_test;
   localparam logic [7:0] IDS [5] = '{8'h21, 8'h32, 8'h43, 8'h54, 8'h65};
   logic clk, rst, tx_start, tx_ent_valid, tb_rx_v, slow, echo_v, rx_v;
   logic tx_ent_ready, tx_valid, tx_busy, tx_err, tx_ready;
   logic rx_hdr_valid, rx_ent_valid, rx_wake, rx_err;
   logic [7:0] tx_byte, echo_b, tb_rx_b, rx_b;
   logic [127:0] tx_ent, rx_ent;
   mife_pkg::mife_tx_hdr_t tx_hdr;
   mife_pkg::mife_rx_hdr_t rx_hdr, last_hdr;
   logic [127:0] ents[$], rxq[$];
   logic [7:0] rxb[$];
   int fail_count = 0, checks_done = 0;
   int hdr_n, err_n, wake_n, txerr_n;

   assign rx_v = echo_v | tb_rx_v;
   assign rx_b = tb_rx_v ? tb_rx_b : echo_b;

   mife_framer #(.ID_APPLICATION_SPECIFIC_ELEMENT(IDS[0]), .ID_PROBE(IDS[1]), .ID_HIB(IDS[2]),
      .ID_MASTER_KEY_IDENTIFIER(IDS[3]), .ID_MAB(IDS[4])) uut (.core_clk_i(clk),
      .sys_rst_i(rst), .tx_start_i(tx_start), .tx_hdr_i(tx_hdr),
      .tx_ent_valid_i(tx_ent_valid), .tx_ent_i(tx_ent),
      .tx_ent_ready_o(tx_ent_ready), .tx_valid_o(tx_valid),
      .tx_byte_o(tx_byte), .tx_ready_i(tx_ready), .tx_busy_o(tx_busy),
      .tx_err_o(tx_err), .rx_start_i(rst), .rx_valid_i(rx_v),
      .rx_byte_i(rx_b), .rx_hdr_valid_o(rx_hdr_valid), .rx_hdr_o(rx_hdr),
      .rx_ent_valid_o(rx_ent_valid), .rx_ent_o(rx_ent),
      .rx_wake_next_o(rx_wake), .rx_err_o(rx_err));

   mife_sink_model sink (.clk_i(clk), .rst_i(rst), .slow_i(slow),
      .valid_i(tx_valid), .byte_i(tx_byte), .ready_o(tx_ready),
      .echo_valid_o(echo_v), .echo_byte_o(echo_b));

   always #10 clk = ~clk;

   always @(posedge clk) begin
      if (rx_ent_valid) rxq.push_back(rx_ent);
      if (rx_hdr_valid) begin
         hdr_n++;
         last_hdr = rx_hdr;
      end
      if (rx_err) err_n++;
      if (rx_wake) wake_n++;
      if (tx_err) txerr_n++;
   end

   task automatic close_out();
      if (fail_count == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // Builds one element from ents, then checks the octets on the wire and
   // what the parser recovers from the echoed stream.
   task automatic tx_run(input mife_pkg::mife_kind_t k, input logic [15:0] tg,
                         input logic [15:0] sp, input int esz);
      logic [7:0] exp[$];
      mife_pkg::mife_rx_hdr_t eh;
      int hl, len, to;
      hl = (k == mife_pkg::MIFE_PROBE) ? 4 : (k == mife_pkg::MIFE_APPLICATION_SPECIFIC_ELEMENT) ? 2 : 0;
      len = hl + ents.size() * esz;
      exp = {IDS[k], 8'(len)};
      if (hl == 4) exp = {exp, tg[7:0], tg[15:8]};
      if (hl > 0) exp = {exp, sp[7:0], sp[15:8]};
      foreach (ents[i]) for (int b = 0; b < esz; b++) exp.push_back(ents[i][8*b +: 8]);
      eh = '{k, 8'(len), (hl == 4) ? tg : 16'h0000, (hl > 0) ? sp : 16'h0000};
      sink.got.delete();
      rxq.delete();
      hdr_n = 0;
      wake_n = 0;
      tx_hdr = '{k, 8'(ents.size()), tg, sp};
      tx_start = 1'b1;
      @(posedge clk);
      #1 tx_start = 1'b0;
      foreach (ents[i]) begin
         tx_ent = ents[i];
         tx_ent_valid = 1'b1;
         to = 0;
         while (!tx_ent_ready && to < 500) begin @(posedge clk); #1 to++; end
         @(posedge clk);
         #1;
      end
      tx_ent_valid = 1'b0;
      to = 0;
      while (tx_busy && to < 500) begin @(posedge clk); to++; end
      repeat (4) @(posedge clk);
      #1 `CHK(sink.got.size(), exp.size())
      foreach (exp[i]) `CHK(sink.got[i], exp[i])
      `CHK(hdr_n, 1)
      `CHK(last_hdr, eh)
      `CHK(rxq.size(), ents.size())
      foreach (rxq[i]) `CHK(rxq[i], ents[i])
   endtask

   task automatic rx_send();
      foreach (rxb[i]) begin
         tb_rx_v = 1'b1;
         tb_rx_b = rxb[i];
         @(posedge clk);
         #1;
      end
      tb_rx_v = 1'b0;
      tb_rx_b = ~tb_rx_b;
   endtask

   task automatic s_hib();
      slow = 1'b1;
      ents = {128'h1234, 128'h7BEEF};
      tx_run(mife_pkg::MIFE_HIB, 16'h0000, 16'h0000, 3);
      `CHK(wake_n, 1)
      slow = 1'b0;
   endtask

   task automatic s_master_key_identifier();
      ents = {128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210, 128'h5A5A_0F};
      tx_run(mife_pkg::MIFE_MASTER_KEY_IDENTIFIER, 16'h0000, 16'h0000, 16);
   endtask

   task automatic s_mab();
      // The client hands over the EUI-48 and the bound short address.
      ents = {128'h4321_0300_5E00_0001};
      tx_run(mife_pkg::MIFE_MAB, 16'h0000, 16'h0000, 8);
   endtask

   task automatic s_probe();
      ents = {128'h11, 128'h22, 128'h33};
      tx_run(mife_pkg::MIFE_PROBE, 16'hC0DE, 16'h7A5E, 1);
   endtask

   task automatic s_application_specific_element();
      ents = {128'hFF};
      tx_run(mife_pkg::MIFE_APPLICATION_SPECIFIC_ELEMENT, 16'h0000, 16'h1357, 1);
   endtask

   task automatic s_oversize();
      sink.got.delete();
      txerr_n = 0;
      tx_hdr = '{mife_pkg::MIFE_MAB, 8'h20, 16'h0000, 16'h0000};
      tx_start = 1'b1;
      @(posedge clk);
      #1 tx_start = 1'b0;
      repeat (6) @(posedge clk);
      #1 `CHK(txerr_n, 1)
      `CHK(sink.got.size(), 0)
   endtask

   task automatic s_rx_bad();
      rxq.delete();
      {hdr_n, err_n, wake_n} = '0;
      rxb = {IDS[2], 8'h04, 8'h01, 8'h02, 8'h03, 8'h04, 8'h7E, 8'h02,
             8'hAA, 8'hBB, IDS[2], 8'h03, 8'h5A, 8'hA5, 8'h00};
      rx_send();
      repeat (3) @(posedge clk);
      #1 `CHK(err_n, 1)
      `CHK(hdr_n, 1)
      `CHK(rxq.size(), 1)
      `CHK(rxq[0], 128'hA55A)
      `CHK(wake_n, 1)
   endtask

   initial begin
      {clk, tx_start, tx_ent_valid, tb_rx_v, slow} = '0;
      rst = 1'b1;
      tx_hdr = '0;
      tx_ent = '0;
      tb_rx_b = 8'h00;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      s_hib();
      s_master_key_identifier();
      s_mab();
      s_probe();
      s_application_specific_element();
      s_oversize();
      s_rx_bad();
      close_out();
   end

   initial begin
      #200000;
      fail_count++;
      close_out();
   end
endmodule // mife_framer_test

bind mife_framer mife_framer_chk #(.ID_HIB(ID_HIB)) chk (
   .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .tx_start_i(tx_start_i),
   .tx_hdr_i(tx_hdr_i), .tx_ent_valid_i(tx_ent_valid_i),
   .tx_ent_ready_o(tx_ent_ready_o), .tx_valid_o(tx_valid_o),
   .tx_byte_o(tx_byte_o), .tx_ready_i(tx_ready_i), .tx_busy_o(tx_busy_o),
   .tx_err_o(tx_err_o), .rx_hdr_valid_o(rx_hdr_valid_o), .rx_hdr_o(rx_hdr_o),
   .rx_ent_valid_o(rx_ent_valid_o), .rx_ent_o(rx_ent_o),
   .rx_wake_next_o(rx_wake_next_o), .rx_err_o(rx_err_o));

`default_nettype wire
